// ==== inc/sprc_consts.vh ====
// Purpose : Constants for the sensor request / command check SPI block
// Assumes : Included by the design files by bare name
// Notes   : Definitions only
`ifndef SPRC_CONSTS_VH
`define SPRC_CONSTS_VH

// ==========================================================
// Frame layout
`define SPRC_FRAME_BITS   6'd32
`define SPRC_CNT_W        6
`define SPRC_CMD_HI       31
`define SPRC_CMD_LO       28
`define SPRC_ST_HI        27
`define SPRC_ST_LO        26
`define SPRC_FIX_HI       27
`define SPRC_FIX_LO       8
`define SPRC_SF_HI        9
`define SPRC_SF_LO        8

// ==========================================================
// Check value
`define SPRC_POLY         8'h2f
`define SPRC_SEED_HI      4'hf
`define SPRC_SEED_ZERO    4'h0
`define SPRC_MSG_BITS     24

// ==========================================================
// Basic and detailed status codes
`define SPRC_ST_INIT      2'h0
`define SPRC_ST_NORMAL    2'h1
`define SPRC_ST_SELFTEST  2'h2
`define SPRC_ST_ERROR     2'h3
`define SPRC_SF_SPI_ERR   2'h3

`endif

// ==== hw/sprc_crc8.v ====
// Purpose : Serial 8-bit check register, bit enters at the low end
// Assumes : Same clock as its user, one bit per shift pulse
// Notes   : Fed message then check bits, all zero means intact
`timescale 1ns/1ps
`default_nettype none
`include "sprc_consts.vh"

module sprc_crc8 (
   // Clock and reset
   input  wire       i_core_clk,
   input  wire       i_sys_rst,
   input  wire       i_clk_en,
   // Control
   input  wire       i_load,
   input  wire [7:0] i_seed,
   input  wire       i_shift,
   input  wire       i_bit,
   // Result
   output wire [7:0] o_crc
);

   reg [7:0] crc_r;

   // ==========================================================
   // Shift register; load beats shift so each frame starts clean
   always @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         crc_r <= 8'hff;
      end else if (i_clk_en) begin
         if (i_load) begin
            crc_r <= i_seed;
         end else if (i_shift) begin
            crc_r <= {crc_r[6:0], i_bit} ^ (crc_r[7] ? `SPRC_POLY : 8'h00);
         end
      end
   end

   assign o_crc = crc_r;

endmodule // sprc_crc8
`default_nettype wire

// ==== hw/sprc_spi_sensor.v ====
// Purpose : SPI command decode, sensor data response and command check
// Assumes : SPI mode 0, sclk far slower than i_core_clk (8+ clocks/bit)
// Notes   : Pins are synchronised; reply to a command goes out next frame
// Functional notes
// - Sensor request: lowest command bit one, bits 27..8 zero, check byte last.
// - Upper three command bits pick the measurement source returned.
// - Sensor reply: command echo, basic status, value, extra bits, detail, check.
// - In 16-bit mode the extra low bits fill the optional field.
// - Nibbles 0000,0010,0100,0110,1010,1110 are reserved, payload ignored.
// - Reserved command is answered in the following frame unless errored.
// - Reserved reply has undefined echo and data, valid check byte.
// - Check value covers all 32 received bits, most significant first.
// - Failed check discards the command and sends the error reply.
// - Seed preloaded, then message and check bits shifted in low end.
// - All-zero remainder after last bit means intact, otherwise corrupt.
// - Polynomial x^8+x^5+x^3+x^2+x+1.
// - Seed all ones for setting 0000, else ones over the setting.
// - Reply to a command goes out in the next frame.
// - Sensor value sampled at the select falling edge of the reply frame.
// - Reply check over reply bits plus eight zeros, same polynomial and seed.
// - Basic status 00 init, 01 normal, 10 self-test, 11 error; prior state.
`timescale 1ns/1ps
`default_nettype none
`include "sprc_consts.vh"

module sprc_spi_sensor (
   // Clock, reset, enable
   input  wire        i_core_clk,
   input  wire        i_sys_rst,
   input  wire        i_clk_en,
   // SPI pins (asynchronous)
   input  wire        i_cs_n,
   input  wire        i_sclk,
   input  wire        i_mosi,
   output wire        o_miso,
   output wire        o_miso_oe,
   // Configuration
   input  wire [3:0]  i_check_seed_setting,
   input  wire        i_res16_en,
   // Device state
   input  wire        i_init_done,
   input  wire        i_self_test,
   input  wire        i_int_error,
   input  wire [1:0]  i_detailed_status,
   // Sensor front end
   output wire [2:0]  o_measurement_source_select,
   input  wire [15:0] i_sensor_value,
   // Events
   output wire        o_cmd_accept,
   output wire        o_cmd_error
);

   // Pending reply kinds, one-hot
   localparam [3:0] K_NONE = 4'b0001;
   localparam [3:0] K_SENS = 4'b0010;
   localparam [3:0] K_RSVD = 4'b0100;
   localparam [3:0] K_ERR  = 4'b1000;
   // Link states, one-hot
   localparam [1:0] L_IDLE  = 2'b01;
   localparam [1:0] L_FRAME = 2'b10;

   // ==========================================================
   // Functions
   function [7:0] seed_of;
      input [3:0] s;
      begin
         seed_of = (s == `SPRC_SEED_ZERO) ? 8'hff : {`SPRC_SEED_HI, s};
      end
   endfunction

   function is_reserved;
      input [3:0] c;
      begin
         case (c)
            4'h0, 4'h2, 4'h4, 4'h6, 4'ha, 4'he: is_reserved = 1'b1;
            default: is_reserved = 1'b0;
         endcase
      end
   endfunction

   function [1:0] basic_of;
      input init_done;
      input self_test;
      input int_err;
      begin
         if (int_err)
            basic_of = `SPRC_ST_ERROR;
         else if (self_test)
            basic_of = `SPRC_ST_SELFTEST;
         else if (!init_done)
            basic_of = `SPRC_ST_INIT;
         else
            basic_of = `SPRC_ST_NORMAL;
      end
   endfunction

   // Augmented check: message bits then eight zeros
   function [7:0] resp_crc;
      input [23:0] msg;
      input [7:0]  seed;
      reg   [7:0]  c;
      reg          b;
      integer      k;
      begin
         c = seed;
         for (k = 0; k < 32; k = k + 1) begin
            b = (k < `SPRC_MSG_BITS) ? msg[23 - k] : 1'b0;
            c = {c[6:0], b} ^ (c[7] ? `SPRC_POLY : 8'h00);
         end
         resp_crc = c;
      end
   endfunction

   // ==========================================================
   // Pin synchronisers, two flops before any use
   reg [1:0] cs_s_r;
   reg [1:0] sck_s_r;
   reg [1:0] mosi_s_r;
   reg       sck_d_r;
   reg       cs_d_r;

   always @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         cs_s_r   <= 2'h3;
         sck_s_r  <= 2'h0;
         mosi_s_r <= 2'h0;
         sck_d_r  <= 1'b0;
         cs_d_r   <= 1'b1;
      end else if (i_clk_en) begin
         cs_s_r   <= {cs_s_r[0], i_cs_n};
         sck_s_r  <= {sck_s_r[0], i_sclk};
         mosi_s_r <= {mosi_s_r[0], i_mosi};
         sck_d_r  <= sck_s_r[1];
         cs_d_r   <= cs_s_r[1];
      end
   end

   wire cs_n    = cs_s_r[1];
   wire sck     = sck_s_r[1];
   wire cs_fall = cs_d_r & ~cs_n;
   wire cs_rise = ~cs_d_r & cs_n;
   wire sck_up  = ~sck_d_r & sck & ~cs_n;
   wire sck_dn  = sck_d_r & ~sck & ~cs_n;

   // ==========================================================
   // Frame state and receive path
   reg  [1:0]                link_r;
   reg  [`SPRC_CNT_W-1:0]    bit_cnt_r;
   reg  [31:0]               rx_r;
   reg                       start_bad_r;
   reg  [31:0]               tx_r;
   reg  [3:0]                kind_r;
   reg  [3:0]                pcmd_r;
   reg  [1:0]                pst_r;
   reg  [1:0]                psf_r;
   reg  [2:0]                src_r;
   reg                       acc_r;
   reg                       err_r;
   wire [7:0]                chk;
   wire [7:0]                seed = seed_of(i_check_seed_setting);

   // Command check register, reseeded at every frame start
   sprc_crc8 u_chk (
      .i_core_clk (i_core_clk),
      .i_sys_rst  (i_sys_rst),
      .i_clk_en   (i_clk_en),
      .i_load     (cs_fall),
      .i_seed     (seed),
      .i_shift    (sck_up),
      .i_bit      (mosi_s_r[1]),
      .o_crc      (chk)
   );

   // ==========================================================
   // Frame end classification
   wire [3:0] rcmd     = rx_r[`SPRC_CMD_HI:`SPRC_CMD_LO];
   wire       len_ok   = (bit_cnt_r == `SPRC_FRAME_BITS);
   wire       chk_ok   = (chk == 8'h00);
   wire       pins_ok  = ~start_bad_r & ~sck;
   wire       frame_ok = len_ok & chk_ok & pins_ok;
   wire       fix_zero = (rx_r[`SPRC_FIX_HI:`SPRC_FIX_LO] == 20'h00000);
   wire       is_sens  = rcmd[0] & fix_zero;
   wire       is_rsvd  = is_reserved(rcmd);

   // ==========================================================
   // Reply assembly at the frame start
   reg  [23:0] msg;
   wire [15:0] val = i_sensor_value;

   always @* begin
      msg = 24'h000000;
      case (kind_r)
         K_SENS: begin
            msg = {pcmd_r, pst_r, val[15:4],
                   (i_res16_en ? val[3:0] : 4'h0),
                   psf_r};
         end
         K_ERR: begin
            msg = {pcmd_r, `SPRC_ST_ERROR, 16'h0000, `SPRC_SF_SPI_ERR};
         end
         K_RSVD: begin
            msg = 24'h000000;
         end
         K_NONE: begin
            msg = 24'h000000;
         end
         default: begin
            msg = 24'h000000;
         end
      endcase
   end

   wire [31:0] resp = {msg, resp_crc(msg, seed)};

   // ==========================================================
   // Link machine: count, receive, shift out, decide at the end
   always @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         link_r      <= L_IDLE;
         bit_cnt_r   <= {`SPRC_CNT_W{1'b0}};
         rx_r        <= 32'h00000000;
         start_bad_r <= 1'b0;
         tx_r        <= 32'h00000000;
      end else if (i_clk_en) begin
         case (link_r)
            L_IDLE: begin
               if (cs_fall) begin
                  link_r      <= L_FRAME;
                  bit_cnt_r   <= {`SPRC_CNT_W{1'b0}};
                  start_bad_r <= sck;   // Clock must idle low at select
                  tx_r        <= resp;
               end
            end
            L_FRAME: begin
               if (cs_rise) begin
                  link_r <= L_IDLE;
               end else begin
                  if (sck_up) begin
                     rx_r <= {rx_r[30:0], mosi_s_r[1]};
                     // Saturate so an overlong frame stays wrong
                     if (bit_cnt_r != {`SPRC_CNT_W{1'b1}})
                        bit_cnt_r <= bit_cnt_r + 1'b1;
                  end
                  if (sck_dn)
                     tx_r <= {tx_r[30:0], 1'b0};
               end
            end
            default: begin
               link_r <= L_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // Pending reply for the next frame, status taken at frame end
   always @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         kind_r <= K_NONE;
         pcmd_r <= 4'h0;
         pst_r  <= `SPRC_ST_INIT;
         psf_r  <= 2'h0;
         src_r  <= 3'h0;
         acc_r  <= 1'b0;
         err_r  <= 1'b0;
      end else if (i_clk_en) begin
         acc_r <= 1'b0;
         err_r <= 1'b0;
         if (cs_rise && (link_r == L_FRAME)) begin
            pcmd_r <= rcmd;
            pst_r  <= basic_of(i_init_done, i_self_test, i_int_error);
            psf_r  <= i_detailed_status;
            if (!frame_ok) begin
               kind_r <= K_ERR;
               err_r  <= 1'b1;
            end else if (is_sens) begin
               kind_r <= K_SENS;
               src_r  <= rcmd[3:1];
               acc_r  <= 1'b1;
            end else if (is_rsvd) begin
               kind_r <= K_RSVD;
               acc_r  <= 1'b1;
            end else begin
               // Bad fixed bits or unsupported command
               kind_r <= K_ERR;
               err_r  <= 1'b1;
            end
         end
      end
   end

   // ==========================================================
   // Outputs
   assign o_miso                      = tx_r[31];
   assign o_miso_oe                   = (link_r == L_FRAME);
   assign o_measurement_source_select = src_r;
   assign o_cmd_accept                = acc_r;
   assign o_cmd_error                 = err_r;

endmodule // sprc_spi_sensor
`default_nettype wire

// ==== verification/sprc_spi_sensor_asserts.sv ====
// Purpose: Port checks for the SPI sensor block
// Assumes: Checks pause while the clock enable is low
// Notes  : Repeat counts cover the pin synchronisers
`timescale 1ns/1ps
`default_nettype none
module sprc_chk (
   input wire logic       i_core_clk,
   input wire logic       i_sys_rst,
   input wire logic       i_clk_en,
   input wire logic       i_cs_n,
   input wire logic       i_sclk,
   input wire logic       o_miso,
   input wire logic       o_miso_oe,
   input wire logic [2:0] o_measurement_source_select,
   input wire logic       o_cmd_accept,
   input wire logic       o_cmd_error
);
   // =====
   // Frame and verdict checks
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_sys_rst || !i_clk_en);
   a_oe_active: assert property (!i_cs_n [*5] |-> o_miso_oe)
      else $error("oe low in frame");
   a_oe_release: assert property (i_cs_n [*5] |-> !o_miso_oe)
      else $error("oe high when idle");
   a_miso_steady: assert property (i_sclk [*4] |-> $stable(o_miso))
      else $error("miso moved");
   a_decide_end: assert property ($fell(o_miso_oe) |-> (o_cmd_accept || o_cmd_error))
      else $error("no verdict");
   a_event_excl: assert property (o_cmd_accept |-> !o_cmd_error)
      else $error("two verdicts");
   a_accept_pulse: assert property (o_cmd_accept |=> !o_cmd_accept)
      else $error("long accept");
   a_error_pulse: assert property (o_cmd_error |=> !o_cmd_error)
      else $error("long error");
   a_select_hold: assert property (!o_cmd_accept |-> $stable(o_measurement_source_select))
      else $error("select moved");
   a_event_late: assert property ((o_cmd_accept || o_cmd_error) |-> $past(i_cs_n, 2))
      else $error("early verdict");
   c_accept: cover property (o_cmd_accept);
   c_error: cover property (o_cmd_error);
   c_back: cover property (o_cmd_accept ##[1:400] o_cmd_error);
endmodule // sprc_chk
bind sprc_spi_sensor sprc_chk i_sprc_chk (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_cs_n(i_cs_n),
   .i_clk_en(i_clk_en), .i_sclk(i_sclk), .o_miso(o_miso), .o_miso_oe(o_miso_oe),
   .o_measurement_source_select(o_measurement_source_select), .o_cmd_accept(o_cmd_accept),
   .o_cmd_error(o_cmd_error));
`default_nettype wire

// ==== verification/sprc_host.sv ====
// Purpose: SPI host model, mode 0, 32-bit frames
// Assumes: Half period in core clocks, 4 or more
// Notes  : Reply bits taken at the end of the high phase
`timescale 1ns/1ps
`default_nettype none
module sprc_host (
   input  wire logic i_core_clk,
   input  wire logic i_miso,
   output var  logic o_cs_n,
   output var  logic o_sclk,
   output var  logic o_mosi
);
   // =====
   // Idle: deselected, clock low
   initial begin
      o_cs_n = 1'b1;
      o_sclk = 1'b0;
      o_mosi = 1'b0;
   end
   // One frame; the clock stands still outside it
   task automatic xfer(input logic [31:0] cmd, input int half, output logic [31:0] rsp);
      @(posedge i_core_clk);
      o_cs_n <= 1'b0;
      for (int i = 31; i >= 0; i--) begin
         o_mosi <= cmd[i];
         repeat (half) @(posedge i_core_clk);
         o_sclk <= 1'b1;
         repeat (half) @(posedge i_core_clk);
         rsp[i] = i_miso;
         o_sclk <= 1'b0;
      end
      repeat (half) @(posedge i_core_clk);
      o_cs_n <= 1'b1;
      o_mosi <= ~o_mosi; // No stale bit once released
      repeat (12) @(posedge i_core_clk);
   endtask
endmodule // sprc_host
`default_nettype wire

// ==== verification/tb.sv ====
// Purpose: Self-checking bench for the SPI sensor block
// Assumes: 25 MHz core clock, 320 ns sclk
// Notes  : A reply is judged in the frame after its command
`timescale 1ns/1ps
`default_nettype none
module tb;
   // =====
   // Design inputs and outputs
   logic        clk = 1'b0, rst = 1'b1, idone = 1'b1, stest = 1'b0, ierr = 1'b0, r16 = 1'b0, cen = 1'b1;
   logic [3:0]  seed = 4'h0;
   logic [1:0]  det = 2'h0;
   logic [15:0] sval = 16'h0;
   logic        cs_n, sclk, mosi, miso, oe, acc, err;
   logic [2:0]  sel;
   logic [31:0] r;
   int          n_mismatch = 0, num_checks = 0, n_acc = 0, n_err = 0;
   // Clock, front end value per source, verdict tally
   always #20 clk = ~clk;
   always @(posedge clk) sval <= {sel, 13'h1a5c};
   always @(posedge clk) begin
      n_acc += (acc === 1'b1);
      n_err += (err === 1'b1);
   end
   sprc_spi_sensor i_sprc_spi_sensor (.i_core_clk(clk), .i_sys_rst(rst), .i_clk_en(cen), .i_cs_n(cs_n),
      .i_sclk(sclk), .i_mosi(mosi), .o_miso(miso), .o_miso_oe(oe), .i_check_seed_setting(seed),
      .i_res16_en(r16), .i_init_done(idone), .i_self_test(stest), .i_int_error(ierr),
      .i_detailed_status(det), .o_measurement_source_select(sel), .i_sensor_value(sval),
      .o_cmd_accept(acc), .o_cmd_error(err));
   sprc_host i_sprc_host (.i_core_clk(clk), .i_miso(miso), .o_cs_n(cs_n), .o_sclk(sclk), .o_mosi(mosi));
   // =====
   // Helpers: mk appends the check byte over 24 bits plus eight zeros
   function automatic logic [31:0] mk(input logic [23:0] m);
      logic [7:0] c;
      c = (seed == 4'h0) ? 8'hff : {4'hf, seed};
      for (int i = 31; i >= 8; i--) c = {c[6:0], m[i-8]} ^ (c[7] ? 8'h2f : 8'h00);
      for (int i = 0; i < 8; i++) c = {c[6:0], 1'b0} ^ (c[7] ? 8'h2f : 8'h00);
      return {m, c};
   endfunction
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", name, exp, got);
      end
   endtask
   // Command, then a reserved filler whose frame carries the reply
   task automatic pair(input logic [31:0] cmd, input logic [23:0] exp, input string name);
      i_sprc_host.xfer(cmd, 4, r);
      i_sprc_host.xfer(mk(24'h0), 4, r);
      chk(name, mk(exp), r);
   endtask
   // =====
   // Scenarios
   task automatic t_reserved;
      logic [3:0] rsv [6];
      int         a0;
      rsv = '{4'h0, 4'h2, 4'h4, 4'h6, 4'ha, 4'he};
      a0 = n_acc;
      i_sprc_host.xfer(mk(24'h0), 4, r);
      chk("first reply", mk(24'h0), r);
      foreach (rsv[k]) pair(mk({rsv[k], 20'hfffff}), 24'h0, "reserved reply");
      chk("accept count", a0 + 13, n_acc);
      chk("error count", 0, n_err);
   endtask
   // Every source, status and length mode once, eight of the sixteen seed settings
   task automatic t_sensor;
      logic [15:0] v;
      logic [1:0]  st;
      for (int i = 0; i < 8; i++) begin
         seed <= {i[2:0], i[0]};
         r16 <= i[0];
         det <= i[1:0];
         ierr <= (i == 7);
         stest <= (i == 6);
         idone <= (i != 5);
         @(posedge clk);
         st = (i == 7) ? 2'h3 : (i == 6) ? 2'h2 : (i == 5) ? 2'h0 : 2'h1;
         v = {i[2:0], 13'h1a5c};
         pair(mk({i[2:0], 1'b1, 20'h0}), {i[2:0], 1'b1, st, v[15:4], r16 ? v[3:0] : 4'h0, i[1:0]},
              "sensor reply");
         chk("source select", i, sel);
      end
   endtask
   // Bad check byte, nonzero fixed bit, unhandled command
   task automatic t_errors;
      logic [31:0] bad [3];
      logic [2:0]  s0;
      int          e0;
      ierr <= 1'b0;
      stest <= 1'b0;
      @(posedge clk);
      bad = '{mk({4'h7, 20'h0}) ^ 32'h1, mk({4'h7, 20'h1}), mk({4'h8, 20'h0})};
      s0 = sel;
      e0 = n_err;
      foreach (bad[k]) pair(bad[k], {bad[k][31:28], 2'h3, 16'h0, 2'h3}, "error reply");
      chk("select kept", s0, sel);
      chk("error count", e0 + 3, n_err);
   endtask
   // Enable low: a corrupt frame sent meanwhile must leave no trace
   task automatic t_freeze;
      int e0, a0;
      e0 = n_err;
      a0 = n_acc;
      cen <= 1'b0;
      @(posedge clk);
      i_sprc_host.xfer(mk({4'h7, 20'h0}) ^ 32'h1, 4, r);
      cen <= 1'b1;
      @(posedge clk);
      i_sprc_host.xfer(mk(24'h0), 4, r);
      chk("frozen reply", mk(24'h0), r);
      chk("frozen error count", e0, n_err);
      chk("frozen accept count", a0 + 1, n_acc);
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      t_reserved();
      t_sensor();
      t_errors();
      t_freeze();
      print_verdict();
   end
   // Watchdog: the run needs about 0.4 ms
   initial begin
      #1000000;
      n_mismatch++;
      print_verdict();
   end
endmodule // tb
`default_nettype wire
